/* core/hsup_defs.svh */
`ifndef HSUP_DEFS_SVH
`define HSUP_DEFS_SVH
// -----------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------
`define HSUP_CTRL 8'h00
`define HSUP_KEY 8'h04
`define HSUP_GAIN 8'h08
`define HSUP_SETPT 8'h0C
`define HSUP_LIMIT 8'h10
`define HSUP_BETA 8'h14
`define HSUP_TEMP 8'h18
`define HSUP_STAT 8'h1C
`define HSUP_STEP0 8'h20
`define HSUP_NSTEP 8'h34
`define HSUP_DISP 8'h38
`define HSUP_ILIM 8'h3C
// -----------------------------------------------------------
// ranges and reset values, temperatures in 0.1 C
// -----------------------------------------------------------
`define HSUP_TLIM_LO 16'sh00C8
`define HSUP_TLIM_HI 16'sh0802
`define HSUP_SETPT_CAP 16'sh07D0
`define HSUP_GAIN_MAX 8'hFA
`define HSUP_BETA_RST 16'h0F82
`define HSUP_SETPT_RST 16'sh00FA
`define HSUP_PLIM_RST 16'h00B4
`define HSUP_PGAIN_RST 8'h0A
`define HSUP_STEP_MAX 3'h5
`define HSUP_F_OFS 17'sh00140
`define HSUP_K_OFS 17'sh00AAC
`define HSUP_TRIM_MAX 16'sh03E8
// power in 0.1 W, current in mA, from a 24 V output ceiling
`define HSUP_VOUT 32'h00000018
`define HSUP_PWR_SCALE 32'h00000064
// -----------------------------------------------------------
// timing
// -----------------------------------------------------------
`define HSUP_CLK_NS 20
`define HSUP_SEC_NS 1000000000
`define HSUP_MIN_S 14'h003C
`define HSUP_SEC_CYC (`HSUP_SEC_NS / `HSUP_CLK_NS)
`endif

/* core/hsup_pkg.sv */
package hsup_pkg;
   typedef enum logic [1:0] {
      HSUP_IDLE = 2'b00,
      HSUP_RAMP = 2'b01,
      HSUP_HOLD = 2'b11,
      HSUP_DONE = 2'b10
   } hsup_seq_e;
   typedef struct packed {
      logic [7:0] hold;
      logic [7:0] ramp;
      logic signed [15:0] stop;
   } hsup_step_s;
   typedef struct packed {
      logic signed [15:0] temp;
      logic open_ckt;
      logic short_ckt;
   } hsup_sense_s;
endpackage

/* core/hsup_top.sv */
// How it works
// - P gain held within 1..250, I and D gains within 0..250.
// - with trim on outside cycle mode, an offset integrates the set-point error into output.
// - three probe types selectable; thermistor beta programmable, default 3970.
// - temperature limit is clamped into 20.0..205.0 C.
// - set-point never exceeds the lower of limit and 200.0 C.
// - lowering the limit pulls set-point and step stops down to it.
// - heater current limit is power limit divided by 24 V.
// - all values are Celsius inside; F or K only on the display.
// - cycle mode runs one to five steps of stop, ramp and hold.
// - each step ramps set-point to stop, then holds it for hold time.
// - pause freezes the ramp or hold timer; resume continues from there.
// - open or shorted probe replaces the shown temperature by a fault.
// - probe fault disables heater and refuses enable until it clears.
// - reading at or above limit opens relay and raises the alarm.
// - after a trip the relay recloses once reading falls to set-point.
// - trips are counted; the third one also disables the heater.
// - limit alarm stays latched until select or enable key clears it.
// - heater lamp lit only while relay is closed and heater enabled.
// - reset starts in normal mode, heater off, with probe type 0 and set-point 25.0 C.
// - each enable key press without a probe fault toggles the heater on or off.
`include "hsup_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module hsup_top #(
   parameter int unsigned SEC_CYC = `HSUP_SEC_CYC,
   parameter int NSTEP = 5
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire hsup_pkg::hsup_sense_s sense,
   output logic heater_en,
   output logic relay_on,
   output logic heater_led,
   output logic limit_alarm_msg,
   output logic sensor_fault_msg,
   output logic signed [15:0] work_setpt,
   output logic signed [15:0] trim_offset,
   output logic [15:0] current_limit,
   output logic signed [16:0] disp_value,
   output logic [7:0] p_gain,
   output logic [7:0] i_gain,
   output logic [7:0] d_gain,
   output logic [1:0] sensor_sel,
   output logic [15:0] beta
);
   import hsup_pkg::*;

   // -----------------------------------------------------------
   // bus slave
   // -----------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   function automatic logic [7:0] gclamp(input logic [7:0] v, input logic lo1);
      if (v > `HSUP_GAIN_MAX) return `HSUP_GAIN_MAX;
      if (lo1 && v == 8'h00) return 8'h01;
      return v;
   endfunction

   logic ph_wr;
   logic [7:0] ph_addr;
   logic wr_key, wr_set, wr_lim;
   logic key_en, key_sel;
   logic [31:0] rd_mux;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ph_wr <= 1'b0;
         ph_addr <= 8'h00;
      end else if (hready) begin
         ph_wr <= hsel && htrans[1] && hwrite;
         ph_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign wr_key = ph_wr && hit(ph_addr, `HSUP_KEY);
   assign wr_set = ph_wr && hit(ph_addr, `HSUP_SETPT);
   assign wr_lim = ph_wr && hit(ph_addr, `HSUP_LIMIT);
   assign key_en = wr_key && hwdata[0];
   assign key_sel = wr_key && hwdata[1];

   // -----------------------------------------------------------
   // settings
   // -----------------------------------------------------------
   logic cyc_mode, pause, tune;
   logic [1:0] units;
   logic signed [15:0] setpt, temp_limit, eff_max, lim_in;
   logic [15:0] power_limit;
   logic [2:0] nsteps;
   hsup_step_s steps [NSTEP];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cyc_mode <= 1'b0;
         pause <= 1'b0;
         tune <= 1'b0;
         sensor_sel <= 2'h0;
         units <= 2'h0;
      end else if (ph_wr && hit(ph_addr, `HSUP_CTRL)) begin
         cyc_mode <= hwdata[0];
         pause <= hwdata[1];
         tune <= hwdata[2];
         sensor_sel <= (hwdata[4:3] == 2'h3) ? 2'h0 : hwdata[4:3];
         units <= (hwdata[6:5] == 2'h3) ? 2'h0 : hwdata[6:5];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p_gain <= `HSUP_PGAIN_RST;
         i_gain <= 8'h00;
         d_gain <= 8'h00;
      end else if (ph_wr && hit(ph_addr, `HSUP_GAIN)) begin
         p_gain <= gclamp(hwdata[7:0], 1'b1);
         i_gain <= gclamp(hwdata[15:8], 1'b0);
         d_gain <= gclamp(hwdata[23:16], 1'b0);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) beta <= `HSUP_BETA_RST;
      else if (ph_wr && hit(ph_addr, `HSUP_BETA)) beta <= hwdata[15:0];
   end

   assign lim_in = $signed(hwdata[15:0]);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         temp_limit <= `HSUP_TLIM_HI;
         power_limit <= `HSUP_PLIM_RST;
      end else if (wr_lim) begin
         if (lim_in < `HSUP_TLIM_LO) temp_limit <= `HSUP_TLIM_LO;
         else if (lim_in > `HSUP_TLIM_HI) temp_limit <= `HSUP_TLIM_HI;
         else temp_limit <= lim_in;
         power_limit <= hwdata[31:16];
      end
   end

   assign eff_max = (temp_limit < `HSUP_SETPT_CAP) ? temp_limit : `HSUP_SETPT_CAP;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) setpt <= `HSUP_SETPT_RST;
      else if (wr_set) setpt <= ($signed(hwdata[15:0]) > eff_max) ?
                                eff_max : $signed(hwdata[15:0]);
      else if (setpt > eff_max) setpt <= eff_max;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) nsteps <= 3'h1;
      else if (ph_wr && hit(ph_addr, `HSUP_NSTEP)) begin
         if (hwdata[2:0] == 3'h0) nsteps <= 3'h1;
         else if (hwdata[2:0] > `HSUP_STEP_MAX) nsteps <= `HSUP_STEP_MAX;
         else nsteps <= hwdata[2:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NSTEP; g++) begin : g_step
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) steps[g] <= {8'h00, 8'h00, `HSUP_SETPT_RST};
            else if (ph_wr && hit(ph_addr, `HSUP_STEP0 + 8'(4 * g)))
               steps[g] <= hwdata;
            else if (steps[g].stop > temp_limit)
               steps[g].stop <= temp_limit;
         end
      end
   endgenerate

   // -----------------------------------------------------------
   // enable, sensor fault and limit trip
   // -----------------------------------------------------------
   logic fault, overt, tripped, next_en, next_trip;
   logic [1:0] trips;
   logic signed [15:0] meas;

   assign meas = sense.temp;
   assign fault = sense.open_ckt || sense.short_ckt;
   assign overt = heater_en && !tripped && !fault && (meas >= temp_limit);

   always_comb begin
      next_en = heater_en;
      if (fault) next_en = 1'b0;
      else if (key_en) next_en = !heater_en;
      else if (overt && trips == 2'h2) next_en = 1'b0;
      next_trip = tripped;
      if (!next_en) next_trip = 1'b0;
      else if (overt) next_trip = 1'b1;
      else if (tripped && meas <= work_setpt) next_trip = 1'b0;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         heater_en <= 1'b0;
         tripped <= 1'b0;
         relay_on <= 1'b0;
         heater_led <= 1'b0;
      end else begin
         heater_en <= next_en;
         tripped <= next_trip;
         relay_on <= next_en && !next_trip;
         heater_led <= next_en && !next_trip;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) trips <= 2'h0;
      else if (!heater_en) trips <= 2'h0;
      else if (overt) trips <= trips + 2'h1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) limit_alarm_msg <= 1'b0;
      else if (overt) limit_alarm_msg <= 1'b1;
      else if (key_en || key_sel) limit_alarm_msg <= 1'b0;
   end

   // -----------------------------------------------------------
   // second tick and cycle sequencer
   // -----------------------------------------------------------
   logic active, tick;
   logic [31:0] div;
   logic [13:0] elapsed, ramp_s, hold_s;
   logic [2:0] step;
   logic signed [15:0] start;
   hsup_seq_e seq;
   hsup_step_s cur;

   assign active = heater_en && cyc_mode;
   assign cur = steps[step];
   assign ramp_s = 14'(cur.ramp * `HSUP_MIN_S);
   assign hold_s = 14'(cur.hold * `HSUP_MIN_S);
   assign tick = (div == SEC_CYC - 1);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) div <= 32'h0;
      else if (active && pause) div <= div;
      else if (tick) div <= 32'h0;
      else div <= div + 32'h1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         seq <= HSUP_IDLE;
         step <= 3'h0;
         elapsed <= 14'h0;
         start <= 16'sh0000;
      end else if (!active) begin
         seq <= HSUP_IDLE;
         step <= 3'h0;
         elapsed <= 14'h0;
      end else if (!pause) begin
         case (seq)
            HSUP_IDLE: begin
               start <= meas;
               seq <= HSUP_RAMP;
            end
            HSUP_RAMP: begin
               if (elapsed >= ramp_s) begin
                  seq <= HSUP_HOLD;
                  elapsed <= 14'h0;
               end else if (tick) elapsed <= elapsed + 14'h1;
            end
            HSUP_HOLD: begin
               if (elapsed >= hold_s) begin
                  elapsed <= 14'h0;
                  if (step + 3'h1 >= nsteps) seq <= HSUP_DONE;
                  else begin
                     step <= step + 3'h1;
                     start <= cur.stop;
                     seq <= HSUP_RAMP;
                  end
               end else if (tick) elapsed <= elapsed + 14'h1;
            end
            HSUP_DONE: seq <= HSUP_DONE;
            default: seq <= HSUP_IDLE;
         endcase
      end
   end

   logic signed [31:0] num, quo;
   logic signed [15:0] stop_c, ramp_pt, next_work;

   assign stop_c = (cur.stop > eff_max) ? eff_max : cur.stop;
   assign num = 32'(stop_c - start) * $signed({18'h0, elapsed});
   assign quo = (ramp_s == 14'h0) ? 32'sh0 : num / $signed({18'h0, ramp_s});
   assign ramp_pt = 16'(start + quo[15:0]);

   always_comb begin
      case (seq)
         HSUP_RAMP: next_work = ramp_pt;
         HSUP_HOLD: next_work = stop_c;
         HSUP_DONE: next_work = stop_c;
         default: next_work = setpt;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) work_setpt <= `HSUP_SETPT_RST;
      else work_setpt <= next_work;
   end

   // -----------------------------------------------------------
   // offset trim, current limit, display
   // -----------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) trim_offset <= 16'sh0000;
      else if (!tune || !heater_en || cyc_mode || fault) trim_offset <= 16'sh0000;
      else if (tick) begin
         if (meas < work_setpt && trim_offset < `HSUP_TRIM_MAX)
            trim_offset <= trim_offset + 16'sh0001;
         else if (meas > work_setpt && trim_offset > -`HSUP_TRIM_MAX)
            trim_offset <= trim_offset - 16'sh0001;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) current_limit <= 16'h0;
      else current_limit <=
         16'((32'(power_limit) * `HSUP_PWR_SCALE) / `HSUP_VOUT);
   end

   logic signed [16:0] meas_x, next_disp;
   assign meas_x = 17'(meas);
   always_comb begin
      case (units)
         2'h1: next_disp = 17'(meas_x * 17'sd9 / 17'sd5) + `HSUP_F_OFS;
         2'h2: next_disp = meas_x + `HSUP_K_OFS;
         default: next_disp = meas_x;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         disp_value <= 17'sh0;
         sensor_fault_msg <= 1'b0;
      end else begin
         disp_value <= fault ? 17'sh0 : next_disp;
         sensor_fault_msg <= fault;
      end
   end

   // -----------------------------------------------------------
   // read back
   // -----------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0;
      if (haddr[7:0] >= `HSUP_STEP0 && haddr[7:0] < `HSUP_NSTEP && haddr[1:0] == 2'h0)
         rd_mux = steps[3'(haddr[7:2] - 6'h08)];
      else case (haddr[7:0])
         `HSUP_CTRL: rd_mux = {25'h0, units, sensor_sel, tune, pause, cyc_mode};
         `HSUP_GAIN: rd_mux = {8'h0, d_gain, i_gain, p_gain};
         `HSUP_SETPT: rd_mux = {16'h0, setpt};
         `HSUP_LIMIT: rd_mux = {power_limit, temp_limit};
         `HSUP_BETA: rd_mux = {16'h0, beta};
         `HSUP_TEMP: rd_mux = {16'h0, work_setpt};
         `HSUP_STAT: rd_mux = {20'h0, step, seq, trips, sensor_fault_msg,
                               limit_alarm_msg, heater_led, relay_on, heater_en};
         `HSUP_NSTEP: rd_mux = {29'h0, nsteps};
         `HSUP_DISP: rd_mux = {15'h0, disp_value};
         `HSUP_ILIM: rd_mux = {16'h0, current_limit};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) hrdata <= 32'h0;
      else if (hready && hsel && htrans[1] && !hwrite) hrdata <= rd_mux;
   end

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_gain_range: assert property (p_gain >= 8'h01 && p_gain <= 8'hFA
      && i_gain <= 8'hFA && d_gain <= 8'hFA)
      else $error("gain out of range");
   a_limit_range: assert property (temp_limit >= 16'sh00C8
      && temp_limit <= 16'sh0802)
      else $error("temperature limit out of range");
   a_setpt_cap: assert property (wr_set |=> setpt <= eff_max)
      else $error("set-point above cap");
   a_pause_freeze: assert property ((active && pause) ##1 active
      |-> $stable(elapsed) && $stable(seq))
      else $error("timer moved during pause");
   a_fault_off: assert property (fault |=> !heater_en && sensor_fault_msg)
      else $error("heater on with probe fault");
   a_overt_trip: assert property (overt |=> !relay_on && limit_alarm_msg)
      else $error("relay not opened at limit");
   a_relay_back: assert property (heater_en && !relay_on && !fault && !key_en
      && meas <= work_setpt |=> relay_on)
      else $error("relay not reclosed");
   a_third_trip: assert property (overt && trips == 2'h2 |=> !heater_en)
      else $error("third trip left heater on");
   a_lamp_gate: assert property (heater_led |-> heater_en && relay_on)
      else $error("lamp lit while off");
   a_trips_zero: assert property (!heater_en |=> trips == 2'h0)
      else $error("trip count kept while disabled");
endmodule // hsup_top
`default_nettype wire

/* dv/hsup_probe_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hsup_probe_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic signed [15:0] temp_req,
   input wire logic open_req,
   input wire logic short_req,
   output var hsup_pkg::hsup_sense_s sense
);
   import hsup_pkg::*;
   // -----------------------------------------------------------
   // probe front end
   // -----------------------------------------------------------
   // a broken probe gives no usable reading, so the value keeps flipping
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sense <= '{temp: 16'sh00FA, open_ckt: 1'b0, short_ckt: 1'b0};
      end else begin
         sense.temp <= (open_req || short_req) ? ~sense.temp : temp_req;
         sense.open_ckt <= open_req;
         sense.short_ckt <= short_req;
      end
   end
endmodule // hsup_probe_model
`default_nettype wire

/* dv/hsup_top_test.sv */
`include "hsup_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module hsup_top_test;
   import hsup_pkg::*;
   // -----------------------------------------------------------
   // bench signals
   // -----------------------------------------------------------
   logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic signed [15:0] t_req = 16'sh00FA;
   logic op_req = 1'b0, sh_req = 1'b0;
   int n_fail = 0, samples_checked = 0;
   wire logic hready;
   logic hreadyout, hresp, heater_en, relay_on, heater_led, limit_alarm_msg, sensor_fault_msg;
   logic signed [15:0] work_setpt, trim_offset;
   logic signed [16:0] disp_value;
   logic [15:0] current_limit, beta;
   logic [7:0] p_gain, i_gain, d_gain;
   logic [1:0] sensor_sel;
   hsup_sense_s sense;
   assign hready = hreadyout;
   always #10 core_clk = ~core_clk;
   hsup_top #(.SEC_CYC(10), .NSTEP(5)) i_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sense(sense),
      .heater_en(heater_en), .relay_on(relay_on), .heater_led(heater_led),
      .limit_alarm_msg(limit_alarm_msg), .sensor_fault_msg(sensor_fault_msg),
      .work_setpt(work_setpt), .trim_offset(trim_offset), .current_limit(current_limit),
      .disp_value(disp_value), .p_gain(p_gain), .i_gain(i_gain), .d_gain(d_gain),
      .sensor_sel(sensor_sel), .beta(beta));
   hsup_probe_model i_probe (.core_clk(core_clk), .rst(rst), .temp_req(t_req),
      .open_req(op_req), .short_req(sh_req), .sense(sense));
   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // samples hready and read data at the rising edge, before that edge's updates land
   task automatic bwait();
      int n;
      n = 0;
      @(posedge core_clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_fail++;
            tally_and_finish();
         end
         @(posedge core_clk);
      end
      rd = hrdata;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      bwait();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      bwait();
      chk(hresp, 32'h0);
      // let the write land before anyone looks at its effect
      @(negedge core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic st(input logic signed [15:0] v);
      @(posedge core_clk);
      t_req <= v;
   endtask
   task automatic do_reset(input int n);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (n) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_settings();
      logic [31:0] ex [4];
      ex = '{32'h000003E8, 32'h00000848, 32'h00000E94, 32'h000003E8};
      do_reset(2);
      cyc(1);
      chk(heater_en, 32'h0);
      chk(work_setpt, 32'h00FA);
      chk(beta, 32'h0F82);
      chk(p_gain, 32'h0A);
      bus(1'b1, `HSUP_GAIN, 32'h00FBFF00);
      chk({d_gain, i_gain, p_gain}, 32'hFAFA01);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, `HSUP_CTRL, k << 3);
         chk(sensor_sel, (k == 3) ? 0 : k);
      end
      bus(1'b1, `HSUP_BETA, 32'h0FA0);
      chk(beta, 32'h0FA0);
      bus(1'b1, `HSUP_LIMIT, 32'h00F00064);
      rchk(`HSUP_LIMIT, 32'hFFFFFFFF, 32'h00F000C8);
      chk(current_limit, 32'h03E8);
      bus(1'b1, `HSUP_LIMIT, 32'h00B40BB8);
      rchk(`HSUP_LIMIT, 32'hFFFFFFFF, 32'h00B40802);
      bus(1'b1, `HSUP_SETPT, 32'h0834);
      cyc(1);
      chk(work_setpt, 32'h07D0);
      bus(1'b1, `HSUP_STEP0, 32'h01010708);
      bus(1'b1, `HSUP_LIMIT, 32'h00B405DC);
      cyc(2);
      chk(work_setpt, 32'h05DC);
      rchk(`HSUP_STEP0, 32'hFFFF, 32'h05DC);
      bus(1'b1, `HSUP_NSTEP, 32'h0);
      rchk(`HSUP_NSTEP, 32'h7, 32'h1);
      bus(1'b1, `HSUP_NSTEP, 32'h7);
      rchk(`HSUP_NSTEP, 32'h7, 32'h5);
      rchk(8'h40, 32'hFFFFFFFF, 32'h0);
      st(16'sh03E8);
      for (int u = 0; u < 4; u++) begin
         bus(1'b1, `HSUP_CTRL, u << 5);
         cyc(3);
         chk(disp_value, ex[u]);
      end
      $display("test settings done");
   endtask
   task automatic t_fault();
      do_reset(2);
      st(16'sh00C8);
      bus(1'b1, `HSUP_CTRL, 32'h4);
      bus(1'b1, `HSUP_KEY, 32'h1);
      cyc(2);
      chk(heater_en, 32'h1);
      chk(heater_led, 32'h1);
      cyc(60);
      chk(trim_offset > 16'sh0000, 32'h1);
      op_req <= 1'b1;
      cyc(3);
      chk(heater_en, 32'h0);
      chk({sensor_fault_msg, disp_value}, 32'h20000);
      bus(1'b1, `HSUP_KEY, 32'h1);
      cyc(2);
      chk(heater_en, 32'h0);
      op_req <= 1'b0;
      sh_req <= 1'b1;
      cyc(3);
      chk(sensor_fault_msg, 32'h1);
      sh_req <= 1'b0;
      cyc(3);
      chk(sensor_fault_msg, 32'h0);
      bus(1'b1, `HSUP_KEY, 32'h1);
      cyc(2);
      chk(heater_en, 32'h1);
      bus(1'b1, `HSUP_KEY, 32'h1);
      cyc(2);
      chk(heater_en, 32'h0);
      $display("test fault done");
   endtask
   task automatic t_trip();
      do_reset(2);
      st(16'sh00FA);
      bus(1'b1, `HSUP_LIMIT, 32'h00B405DC);
      bus(1'b1, `HSUP_SETPT, 32'h03E8);
      bus(1'b1, `HSUP_KEY, 32'h1);
      for (int i = 1; i < 4; i++) begin
         st(16'sh05DC);
         cyc(3);
         chk({relay_on, heater_led, limit_alarm_msg}, 32'h1);
         chk(heater_en, i < 3);
         if (i < 3) begin
            rchk(`HSUP_STAT, 32'h60, i << 5);
            st(16'sh03E8);
            cyc(3);
            chk({relay_on, limit_alarm_msg}, 32'h3);
         end
      end
      rchk(`HSUP_STAT, 32'h60, 32'h0);
      bus(1'b1, `HSUP_KEY, 32'h2);
      cyc(2);
      chk(limit_alarm_msg, 32'h0);
      $display("test trip done");
   endtask
   task automatic t_cycle();
      logic signed [15:0] sp;
      int n;
      do_reset(2);
      st(16'sh00FA);
      bus(1'b1, `HSUP_LIMIT, 32'h00B40802);
      bus(1'b1, `HSUP_STEP0, 32'h010101F4);
      bus(1'b1, `HSUP_NSTEP, 32'h1);
      bus(1'b1, `HSUP_CTRL, 32'h1);
      bus(1'b1, `HSUP_KEY, 32'h1);
      cyc(200);
      rchk(`HSUP_STAT, 32'h180, 32'h080);
      bus(1'b1, `HSUP_CTRL, 32'h3);
      cyc(1);
      sp = work_setpt;
      cyc(300);
      chk(work_setpt, sp);
      rchk(`HSUP_STAT, 32'h180, 32'h080);
      bus(1'b1, `HSUP_CTRL, 32'h1);
      n = 0;
      while (work_setpt !== 16'sh01F4 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk(work_setpt, 32'h01F4);
      chk(n > 300 && n < 500, 32'h1);
      rchk(`HSUP_STAT, 32'h180, 32'h180);
      cyc(700);
      rchk(`HSUP_STAT, 32'h180, 32'h100);
      $display("test cycle done");
   endtask
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (60000) @(posedge core_clk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      do_reset(20);
      t_settings();
      t_fault();
      t_trip();
      t_cycle();
      tally_and_finish();
   end
endmodule // hsup_top_test
`default_nettype wire
